// >>> shared/acc_pkg.sv
// Function
// - controller interface unreachable at frame end gives system fault 0001.
// - unconvertible hex digits or illegal data characters give 0011.
// - only w, r, x, y, s command letters in either case; else 0021.
// - only type suffixes SS and SB are accepted; else 0031.
// - device area other than m, q or i in either case gives 1132.
// - data count of zero or above 128 bytes gives 1232.
// - data type other than x, b, w, d, or forms like db, dd, give 2432.
// - a bit output request without a period in its address gives 7132.
// - address over its area, non-decimal, or past memory size gives 2232.
// - monitor number above 9 gives 0190 on execution, 0290 on registration.
// - unsupported use, such as a bit address in block read, gives 6001.
// - a byte gap longer than the time-out inside a frame gives 6020.
// - missing start or end control character or bad field syntax gives 6030.
// - frame text over 256 bytes gives 6040.
// - block check character mismatch gives 6050.
package acc_pkg;
    localparam int          BYTE_W     = 8;
    localparam int          FIFO_DEPTH = 8;
    localparam logic [7:0]  CH_ENQ     = 8'h05;
    localparam logic [7:0]  CH_EOT     = 8'h04;
    localparam logic [7:0]  CH_PCT     = 8'h25;
    localparam logic [7:0]  CH_DOT     = 8'h2e;
    localparam logic [7:0]  CH_COMMA   = 8'h2c;
    localparam logic [7:0]  CH_UNDER   = 8'h5f;
    localparam logic [15:0] CODE_OK    = 16'h0000;
    localparam logic [15:0] CODE_SYS   = 16'h0001;
    localparam logic [15:0] CODE_DATA  = 16'h0011;
    localparam logic [15:0] CODE_CMD   = 16'h0021;
    localparam logic [15:0] CODE_TYPE  = 16'h0031;
    localparam logic [15:0] CODE_AREA  = 16'h1132;
    localparam logic [15:0] CODE_SIZE  = 16'h1232;
    localparam logic [15:0] CODE_DTYP  = 16'h2432;
    localparam logic [15:0] CODE_FMT   = 16'h7132;
    localparam logic [15:0] CODE_RANGE = 16'h2232;
    localparam logic [15:0] CODE_MONX  = 16'h0190;
    localparam logic [15:0] CODE_MONR  = 16'h0290;
    localparam logic [15:0] CODE_UNSUP = 16'h6001;
    localparam logic [15:0] CODE_TMO   = 16'h6020;
    localparam logic [15:0] CODE_SYN   = 16'h6030;
    localparam logic [15:0] CODE_LEN   = 16'h6040;
    localparam logic [15:0] CODE_BCC   = 16'h6050;
    localparam logic [7:0]  MAX_CNT    = 8'h80;
    localparam logic [8:0]  MAX_TEXT   = 9'h100;
    localparam logic [7:0]  MON_MAX    = 8'h09;
    localparam logic [17:0] M_BYTES    = 18'h00800;
    localparam logic [15:0] BIT_SEG    = 16'h003f;
    localparam logic [15:0] BYTE_SEG   = 16'h0007;
    localparam int          TMO_MS     = 500;
    localparam int          CLK_KHZ    = 200000;

    typedef enum logic [3:0] {
        S_IDLE, S_CMD, S_TYP1, S_TYP2, S_REG1, S_REG2, S_PCT, S_AREA,
        S_DTYP, S_ADR0, S_ADDR, S_CNT1, S_CNT2, S_DATA, S_BCC
    } acc_state_e;

    typedef struct packed {
        logic        ok;
        logic [15:0] code;
        logic [7:0]  cmd;
    } acc_res_s;

    // ascii hex digit to {valid, nibble}
    function automatic logic [4:0] acc_hex(input logic [7:0] c);
        logic [7:0] l;
        l = c | 8'h20;
        if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
        if (l >= 8'h61 && l <= 8'h66) return {1'b1, 4'(l[3:0] + 4'h9)};
        return 5'h00;
    endfunction : acc_hex
endpackage : acc_pkg

// >>> design/acc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module acc_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_sync_b,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output var  logic         in_ready,
    output var  logic         out_valid,
    output var  logic [W-1:0] out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0]   cnt, next_cnt;
    logic          next_in_ready, push, pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = cnt != '0;
    assign out_data  = mem[rp];

    // pointer and fill level update
    always_comb begin
        next_wp = wp;
        next_rp = rp;
        if (push) next_wp = (wp == AW'(D - 1)) ? '0 : AW'(wp + 1'b1);
        if (pop) next_rp = (rp == AW'(D - 1)) ? '0 : AW'(rp + 1'b1);
        next_cnt = (AW + 1)'(cnt + {AW'(0), push} - {AW'(0), pop});
        next_in_ready = next_cnt != (AW + 1)'(D);
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            wp       <= '0;
            rp       <= '0;
            cnt      <= '0;
            in_ready <= 1'b0;
        end else begin
            wp       <= next_wp;
            rp       <= next_rp;
            cnt      <= next_cnt;
            in_ready <= next_in_ready;
        end
    end

    // storage write
    always_ff @(posedge sys_clk) begin
        if (push) mem[wp] <= in_data;
    end
endmodule : acc_fifo
`default_nettype wire

// >>> design/acc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module acc_checker
    import acc_pkg::*;
#(
    parameter int TMO_CYC = TMO_MS * CLK_KHZ
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic             rx_valid,
    input  wire logic [BYTE_W-1:0] rx_data,
    output var  logic             rx_ready,
    input  wire logic             ctl_alive,
    output var  logic             res_valid,
    output var  acc_res_s         res,
    input  wire logic             res_ready
);
    logic             rs1, rst_sync_b;
    logic             fb_valid, take;
    logic [7:0]       fb_data, low;
    logic [4:0]       hx;
    acc_state_e       state, next_state;
    logic             err, next_err, dot, next_dot;
    logic [15:0]      code, next_code, addr, next_addr, typ, next_typ;
    logic [7:0]       cmd, next_cmd, area, next_area, dtyp, next_dtyp;
    logic [7:0]       cnt, next_cnt, bcc, next_bcc, regn;
    logic [8:0]       len, next_len;
    logic [26:0]      tmo, next_tmo;
    logic             next_res_valid;
    acc_res_s         next_res;
    logic             e, fin, cmd_ok, in_frame, len_over;
    logic [15:0]      ec, fc;
    logic [19:0]      dec;
    logic [17:0]      off;

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rs1        <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rs1        <= 1'b1;
            rst_sync_b <= rs1;
        end
    end

    // receive buffer; stalls while a result waits
    acc_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
        .sys_clk    (sys_clk),
        .rst_sync_b (rst_sync_b),
        .in_valid   (rx_valid),
        .in_data    (rx_data),
        .in_ready   (rx_ready),
        .out_valid  (fb_valid),
        .out_data   (fb_data),
        .out_ready  (!res_valid)
    );

    // decode helpers
    assign take     = fb_valid && !res_valid;
    assign low      = fb_data | 8'h20;
    assign hx       = acc_hex(fb_data);
    assign regn     = {addr[3:0], hx[3:0]};
    assign in_frame = state != S_IDLE && state != S_BCC;
    assign cmd_ok   = low inside {8'h77, 8'h72, 8'h78, 8'h79, 8'h73};
    assign dec      = {4'h0, addr} * 20'd10 + {16'h0, fb_data[3:0]};

    // byte offset of an undotted address
    always_comb begin
        case (dtyp)
            8'h78:   off = {5'h00, addr[15:3]};
            8'h77:   off = {1'b0, addr, 1'b0};
            8'h64:   off = {addr, 2'b00};
            default: off = {2'b00, addr};
        endcase
    end

    // frame parser and fault selection
    always_comb begin
        next_state     = state;
        next_err       = err;
        next_code      = code;
        next_cmd       = cmd;
        next_typ       = typ;
        next_area      = area;
        next_dtyp      = dtyp;
        next_addr      = addr;
        next_dot       = dot;
        next_cnt       = cnt;
        next_len       = len;
        next_bcc       = bcc;
        next_tmo       = tmo;
        next_res_valid = res_valid && !res_ready;
        next_res       = res;
        e              = 1'b0;
        ec             = CODE_OK;
        fin            = 1'b0;
        fc             = CODE_OK;
        len_over       = 1'b0;
        if (take) begin
            next_tmo = '0;
            if (in_frame) begin
                next_bcc = 8'(bcc + fb_data);
                if (fb_data != CH_EOT) begin
                    if (len == MAX_TEXT) len_over = 1'b1;
                    else next_len = 9'(len + 1'b1);
                end
            end
            if (state == S_IDLE) begin
                if (fb_data == CH_ENQ) begin
                    next_state = S_CMD;
                    next_err   = 1'b0;
                    next_code  = CODE_OK;
                    next_len   = '0;
                    next_bcc   = CH_ENQ;
                    next_cmd   = '0;
                end else begin
                    fin = 1'b1;
                    fc  = CODE_SYN;
                end
            end else if (state == S_BCC) begin
                fin        = 1'b1;
                next_state = S_IDLE;
                if (fb_data != bcc) fc = CODE_BCC;
                else if (err) fc = code;
                else if (!ctl_alive) fc = CODE_SYS;
            end else if (fb_data == CH_ENQ) begin
                e  = 1'b1;
                ec = CODE_SYN;
            end else if (fb_data == CH_EOT) begin
                next_state = S_BCC;
                if (state != S_DATA) begin
                    e  = 1'b1;
                    ec = CODE_SYN;
                end
            end else begin
                case (state)
                    S_CMD: begin
                        next_cmd   = low;
                        next_state = S_TYP1;
                        if (!cmd_ok) begin
                            e  = 1'b1;
                            ec = CODE_CMD;
                        end
                    end
                    S_TYP1: begin
                        next_typ   = {low, 8'h00};
                        next_state = S_TYP2;
                    end
                    S_TYP2: begin
                        next_typ   = {typ[15:8], low};
                        next_state = (cmd == 8'h78 || cmd == 8'h79) ? S_REG1 : S_PCT;
                        if (!({typ[15:8], low} inside {16'h7373, 16'h7362})) begin
                            e  = 1'b1;
                            ec = CODE_TYPE;
                        end
                    end
                    S_REG1, S_CNT1: begin
                        next_addr  = {12'h000, hx[3:0]};
                        next_state = (state == S_REG1) ? S_REG2 : S_CNT2;
                        if (!hx[4]) begin
                            e  = 1'b1;
                            ec = CODE_DATA;
                        end
                    end
                    S_REG2, S_CNT2: begin
                        next_cnt   = regn;
                        next_state = S_DATA;
                        if (!hx[4]) begin
                            e  = 1'b1;
                            ec = CODE_DATA;
                        end else if (state == S_REG2 && regn > MON_MAX) begin
                            e  = 1'b1;
                            ec = (cmd == 8'h78) ? CODE_MONR : CODE_MONX;
                        end else if (state == S_CNT2 && (regn == '0 || regn > MAX_CNT)) begin
                            e  = 1'b1;
                            ec = CODE_SIZE;
                        end
                    end
                    S_PCT: begin
                        next_state = S_AREA;
                        if (fb_data != CH_PCT) begin
                            e  = 1'b1;
                            ec = CODE_SYN;
                        end
                    end
                    S_AREA: begin
                        next_area  = low;
                        next_state = S_DTYP;
                        if (!(low inside {8'h6d, 8'h71, 8'h69})) begin
                            e  = 1'b1;
                            ec = CODE_AREA;
                        end
                    end
                    S_DTYP: begin
                        next_dtyp  = low;
                        next_state = S_ADR0;
                        next_addr  = '0;
                        next_dot   = 1'b0;
                        if (!(low inside {8'h78, 8'h62, 8'h77, 8'h64})) begin
                            e  = 1'b1;
                            ec = CODE_DTYP;
                        end
                    end
                    S_ADR0, S_ADDR: begin
                        next_state = S_ADDR;
                        if (state == S_ADR0 && (low == 8'h62 || low == 8'h64)) begin
                            e  = 1'b1;
                            ec = CODE_DTYP;
                        end else if (fb_data >= 8'h30 && fb_data <= 8'h39) begin
                            next_addr = (dec[19:16] != '0) ? 16'hffff : dec[15:0];
                        end else if (fb_data == CH_DOT) begin
                            next_dot  = 1'b1;
                            next_addr = '0;
                        end else if (fb_data == CH_COMMA) begin
                            next_state = S_CNT1;
                            e          = 1'b1;
                            if (area == 8'h71 && dtyp == 8'h78 && !dot) begin
                                ec = CODE_FMT;
                            end else if (dot && addr > ((dtyp == 8'h78) ? BIT_SEG : BYTE_SEG)) begin
                                ec = CODE_RANGE;
                            end else if (!dot && area == 8'h6d && off >= M_BYTES) begin
                                ec = CODE_RANGE;
                            end else if (cmd == 8'h72 && typ == 16'h7362 && dtyp == 8'h78) begin
                                ec = CODE_UNSUP;
                            end else begin
                                e = 1'b0;
                            end
                        end else begin
                            e  = 1'b1;
                            ec = CODE_RANGE;
                        end
                    end
                    S_DATA: begin
                        if (!((low >= 8'h61 && low <= 8'h7a) || (fb_data >= 8'h30 && fb_data <= 8'h39)
                              || fb_data inside {CH_PCT, CH_UNDER, CH_COMMA, CH_DOT})) begin
                            e  = 1'b1;
                            ec = CODE_DATA;
                        end
                    end
                    default: next_state = S_IDLE;
                endcase
            end
        end else if (state != S_IDLE && !res_valid) begin
            if (tmo == 27'(TMO_CYC - 1)) begin
                fin        = 1'b1;
                fc         = CODE_TMO;
                next_state = S_IDLE;
            end else begin
                next_tmo = 27'(tmo + 1'b1);
            end
        end
        if (len_over) begin // field checks must not mask or clear it
            e  = 1'b1;
            ec = CODE_LEN;
        end
        if (e && !err) begin
            next_err  = 1'b1;
            next_code = ec;
        end
        if (fin) begin
            next_res_valid = 1'b1;
            next_res       = '{ok: fc == CODE_OK, code: fc, cmd: next_cmd};
            next_tmo       = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state     <= S_IDLE;
            err       <= 1'b0;
            code      <= CODE_OK;
            cmd       <= '0;
            typ       <= '0;
            area      <= '0;
            dtyp      <= '0;
            addr      <= '0;
            dot       <= 1'b0;
            cnt       <= '0;
            len       <= '0;
            bcc       <= '0;
            tmo       <= '0;
            res_valid <= 1'b0;
            res       <= '0;
        end else begin
            state     <= next_state;
            err       <= next_err;
            code      <= next_code;
            cmd       <= next_cmd;
            typ       <= next_typ;
            area      <= next_area;
            dtyp      <= next_dtyp;
            addr      <= next_addr;
            dot       <= next_dot;
            cnt       <= next_cnt;
            len       <= next_len;
            bcc       <= next_bcc;
            tmo       <= next_tmo;
            res_valid <= next_res_valid;
            res       <= next_res;
        end
    end

    // checks on the parser
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_b);
    sequence s_end_byte;
        take && state == S_BCC;
    endsequence
    sequence s_bad_lead;
        take && state == S_IDLE && fb_data != CH_ENQ;
    endsequence
    a_cmd_letter: assert property (take && state == S_CMD && !err && !cmd_ok && fb_data != CH_EOT
        && fb_data != CH_ENQ && len != MAX_TEXT |=> err && code == CODE_CMD)
        else $error("bad command letter not flagged");
    a_lead_enq: assert property (s_bad_lead |=> res_valid && res.code == CODE_SYN)
        else $error("missing start character not reported");
    a_tmo_fire: assert property (state != S_IDLE && !take && !res_valid
        && tmo == 27'(TMO_CYC - 1) |=> res_valid && res.code == CODE_TMO)
        else $error("time-out not reported");
    a_bcc_check: assert property (s_end_byte ##0 fb_data != bcc
        |=> res_valid && res.code == CODE_BCC && state == S_IDLE)
        else $error("check character mismatch not reported");
    a_sys_fault: assert property (s_end_byte ##0 (fb_data == bcc && !err && !ctl_alive)
        |=> res.code == CODE_SYS && !res.ok)
        else $error("system fault not reported");
    a_len_limit: assert property (take && in_frame && len == MAX_TEXT && !err
        && fb_data != CH_EOT |=> err && code == CODE_LEN)
        else $error("text length overflow not flagged");
    a_res_hold: assert property (res_valid && !res_ready |=> res_valid && $stable(res))
        else $error("result changed before it was taken");
    a_mon_limit: assert property (take && state == S_REG2 && !err && hx[4] && regn > MON_MAX
        && fb_data != CH_EOT && len != MAX_TEXT
        |=> code == ((cmd == 8'h78) ? CODE_MONR : CODE_MONX))
        else $error("monitor number limit not flagged");
endmodule : acc_checker
`default_nettype wire

// >>> testbench/acc_host.sv
`timescale 1ns/100ps
`default_nettype none
// host model: queues command bytes and offers them over valid/ready
module acc_host
    import acc_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rx_ready,
    output var  logic             rx_valid,
    output var  logic [BYTE_W-1:0] rx_data
);
    logic [7:0] q[$];
    logic [7:0] last;

    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        last     = 8'h00;
    end

    // hold each byte until taken, then show a changed value while idle
    always @(posedge sys_clk) begin
        if (rx_valid && rx_ready) begin
            last = rx_data;
            void'(q.pop_front());
        end
        #1;
        rx_valid = (q.size() > 0);
        rx_data  = rx_valid ? q[0] : ~last;
    end

    // one raw byte, used for stray bytes and cut-off frames
    task automatic raw(input logic [7:0] b);
        q.push_back(b);
    endtask : raw

    // whole frame with start, end and check byte; bad corrupts the check byte
    task automatic frame(input string s, input bit bad);
        logic [7:0] sum;
        sum = CH_ENQ + CH_EOT;
        q.push_back(CH_ENQ);
        for (int i = 0; i < s.len(); i++) begin
            q.push_back(s[i]);
            sum = sum + s[i];
        end
        q.push_back(CH_EOT);
        q.push_back(bad ? ~sum : sum);
    endtask : frame
endmodule : acc_host
`default_nettype wire

// >>> testbench/test_ascii_command_error_checker.sv
`timescale 1ns/100ps
`default_nettype none
module test_ascii_command_error_checker
    import acc_pkg::*;
;
    logic             sys_clk;
    logic             rst_b;
    logic             rx_valid;
    logic [7:0]       rx_data;
    logic             rx_ready;
    logic             ctl_alive;
    logic             res_valid;
    acc_res_s         res;
    logic             res_ready;
    int               n_mismatch = 0;
    int               compares   = 0;
    acc_res_s         r;
    string            s;

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    acc_checker #(.TMO_CYC(50)) DUT (
        .sys_clk(sys_clk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .ctl_alive(ctl_alive), .res_valid(res_valid), .res(res),
        .res_ready(res_ready)
    );

    acc_host host (
        .sys_clk(sys_clk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data)
    );

    // compare tasks, one per kind of result
    task automatic cmp_code(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t code %h expected %h", $time, got, exp);
        end
    endtask : cmp_code

    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : cmp_bit

    // wait for a result under a bound, then take it for one cycle
    task automatic wait_res();
        for (int i = 0; i < 2000 && res_valid !== 1'b1; i++) @(posedge sys_clk) #1;
        cmp_bit(res_valid, 1'b1);
    endtask : wait_res

    task automatic take(input logic [15:0] exp);
        wait_res();
        r = res;
        res_ready = 1'b1;
        @(posedge sys_clk) #1;
        res_ready = 1'b0;
        cmp_code(r.code, exp);
        cmp_bit(r.ok, exp == CODE_OK);
    endtask : take

    task automatic run(input string f, input bit bad, input logic [15:0] exp);
        host.frame(f, bad);
        take(exp);
    endtask : run

    task automatic t_good();
        run("rSS%mb10,01", 1'b0, CODE_OK);
        cmp_code({8'h00, r.cmd}, 16'h0072);
        run("WsB%qw0.1.0,02", 1'b0, CODE_OK);
    endtask : t_good

    task automatic t_fields();
        run("aSS%mb0,01", 1'b0, CODE_CMD);
        run("rSX%mb0,01", 1'b0, CODE_TYPE);
        run("rSS%zb0,01", 1'b0, CODE_AREA);
        run("rSS%mk0,01", 1'b0, CODE_DTYP);
        run("rSS%mdb0,01", 1'b0, CODE_DTYP);
        run("rSS%mb0,0g", 1'b0, CODE_DATA);
        run("rSB%mx0,01", 1'b0, CODE_UNSUP);
        run("rSSmb0,01", 1'b0, CODE_SYN);
    endtask : t_fields

    task automatic t_count();
        run("rSS%mb0,00", 1'b0, CODE_SIZE);
        run("rSS%mb0,81", 1'b0, CODE_SIZE);
        run("rSS%mb0,80", 1'b0, CODE_OK);
        run("rSS%mb0,01", 1'b0, CODE_OK);
    endtask : t_count

    task automatic t_addr();
        run("wSS%qx5,01", 1'b0, CODE_FMT);
        run("rSS%qx0.0.64,01", 1'b0, CODE_RANGE);
        run("rSS%qx0.0.63,01", 1'b0, CODE_OK);
        run("rSS%mb0.0.8,01", 1'b0, CODE_RANGE);
        run("rSS%mx00a,01", 1'b0, CODE_RANGE);
        run("rSS%mb2048,01", 1'b0, CODE_RANGE);
        run("rSS%mb2047,01", 1'b0, CODE_OK);
    endtask : t_addr

    task automatic t_monitor();
        run("ySS0a", 1'b0, CODE_MONX);
        run("xSS0a", 1'b0, CODE_MONR);
        run("xSS09", 1'b0, CODE_OK);
    endtask : t_monitor

    task automatic t_link();
        ctl_alive = 1'b0;
        run("rSS%mb0,01", 1'b0, CODE_SYS);
        ctl_alive = 1'b1;
        run("rSS%mb0,01", 1'b1, CODE_BCC);
        host.raw(8'h7a);
        take(CODE_SYN);
        host.raw(CH_ENQ);
        host.raw(8'h72);
        take(CODE_TMO);
        s = "wSS%mb0,01";
        for (int i = 0; i < 250; i++) s = {s, "a"};
        run(s, 1'b0, CODE_LEN);
    endtask : t_link

    // result held back: buffer fills and refuses, then drains in order
    task automatic t_fifo();
        host.frame("rSS%mb0,01", 1'b0);
        wait_res();
        host.frame("xSS0a1", 1'b0);
        repeat (30) @(posedge sys_clk) #1;
        cmp_bit(rx_ready, 1'b0);
        cmp_bit(host.q.size() == 1, 1'b1);
        take(CODE_OK);
        take(CODE_MONR);
        cmp_bit(host.q.size() == 0, 1'b1);
    endtask : t_fifo

    task automatic complete_run();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    initial begin
        rst_b     = 1'b0;
        ctl_alive = 1'b1;
        res_ready = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        cmp_bit(rx_ready, 1'b0);
        cmp_bit(res_valid, 1'b0);
        rst_b = 1'b1;
        for (int i = 0; i < 20 && rx_ready !== 1'b1; i++) @(posedge sys_clk) #1;
        t_good();
        t_fields();
        t_count();
        t_addr();
        t_monitor();
        t_link();
        t_fifo();
        complete_run();
    end

    // watchdog sized well beyond the expected run
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule : test_ascii_command_error_checker
`default_nettype wire
